// >>> hw/tcu_capture.sv
// Capture unit: selects an event source, qualifies edges, prescales, and latches the reference count.
// Assumes reference_count is synchronous to core_clk, and a plain byte-wide register port.
`timescale 1ns/1ps
// Overview of operation
// - On a qualified event copy the 16-bit reference count into the capture pair.
// - Mode picks falling, rising, every fourth rising or every sixteenth rising edge.
// - Each capture sets the capture flag in the status register.
// - A new capture overwrites the held value even if unread.
// - A 3-bit select picks one of eight capture sources.
// - A port write on an output-configured pin may create a capture edge.
// - Changing the mode may raise a spurious flag; software clears it afterwards.
// - Prescaler stays cleared while disabled or not in a capture mode.
// - Any reset clears the prescaler.
// - Changing between prescale modes directly keeps the prescaler count.
module tcu_capture #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [COUNT_WIDTH-1:0] reference_count,
  input wire logic remapped_pin_input,
  input wire logic comparator_a_synced,
  input wire logic comparator_b_synced,
  input wire logic pin_change_event,
  input wire logic logic_cell_a_out,
  input wire logic logic_cell_b_out,
  input wire logic logic_cell_c_out,
  input wire logic logic_cell_d_out,
  output logic capture_pulse,
  output logic irq
);
  logic [7:0] unit_control_reg;
  logic [2:0] capture_source_select;
  logic [COUNT_WIDTH-1:0] captured_count;
  logic capture_flag;
  logic capture_irq_enable;
  logic [3:0] prescale_count;
  logic src_prev;
  logic src_sync;
  logic [7:0] next_rdata;

  // Register port decode.
  wire wr_control = reg_write && (reg_addr == tcu_pkg::ADDR_CONTROL);
  wire wr_source = reg_write && (reg_addr == tcu_pkg::ADDR_SOURCE);
  wire wr_enable = reg_write && (reg_addr == tcu_pkg::ADDR_IRQ_ENABLE);
  wire wr_clear = reg_write && (reg_addr == tcu_pkg::ADDR_IRQ_CLEAR);
  wire [3:0] event_mode_field = unit_control_reg[tcu_pkg::CTRL_MODE_LSB +: 4];
  wire module_on = unit_control_reg[tcu_pkg::CTRL_ENABLE_BIT];
  wire result_alignment = unit_control_reg[tcu_pkg::CTRL_ALIGN_BIT];

  // Source multiplexer; every source, comparators included, is resynchronised.
  wire [7:0] source_vec = {logic_cell_d_out, logic_cell_c_out, logic_cell_b_out, logic_cell_a_out,
                           pin_change_event, comparator_b_synced, comparator_a_synced, remapped_pin_input};
  wire source_raw = source_vec[capture_source_select];

  // Pin writes while configured as output simply arrive here as edges.
  tcu_sync u_src_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(source_raw),
    .sync_out(src_sync)
  );

  // Edge qualification on the synchronised level gives exactly one pulse per edge.
  wire rise = src_sync && !src_prev;
  wire fall = !src_sync && src_prev;

  // Mode decode into an event kind.
  tcu_pkg::tcu_event_kind_t kind;
  always_comb begin
    case (event_mode_field)
      tcu_pkg::MODE_FALLING: kind = tcu_pkg::TCU_EV_FALL;
      tcu_pkg::MODE_RISING: kind = tcu_pkg::TCU_EV_RISE;
      tcu_pkg::MODE_RISING_4: kind = tcu_pkg::TCU_EV_PRESCALED;
      tcu_pkg::MODE_RISING_16: kind = tcu_pkg::TCU_EV_PRESCALED;
      default: kind = tcu_pkg::TCU_EV_NONE;
    endcase
  end

  wire capture_mode = module_on && (kind != tcu_pkg::TCU_EV_NONE);
  wire [3:0] prescale_last = (event_mode_field == tcu_pkg::MODE_RISING_16) ?
                             tcu_pkg::PRESCALE_16_LAST : tcu_pkg::PRESCALE_4_LAST;
  // The prescaler is not cleared by a direct switch, so 16 to 4 may fire at once.
  wire prescale_hit = rise && (prescale_count >= prescale_last);
  wire capture_event = module_on && (
    (kind == tcu_pkg::TCU_EV_FALL && fall) ||
    (kind == tcu_pkg::TCU_EV_RISE && rise) ||
    (kind == tcu_pkg::TCU_EV_PRESCALED && prescale_hit));

  // Edge history register.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_prev <= 1'b0;
    end else if (clk_en) begin
      src_prev <= src_sync;
    end
  end

  // Prescaler: cleared by reset or when not capturing, counts rising edges in the prescaled modes and holds in the others.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale_count <= 4'h0;
    end else if (clk_en) begin
      if (!capture_mode) begin
        prescale_count <= 4'h0;
      end else if (kind == tcu_pkg::TCU_EV_PRESCALED && rise) begin
        prescale_count <= prescale_hit ? 4'h0 : prescale_count + 4'h1;
      end
    end
  end

  // Control and source registers; no clearing of the prescaler on a mode write.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unit_control_reg <= tcu_pkg::CONTROL_RESET;
      capture_source_select <= tcu_pkg::SOURCE_RESET;
      capture_irq_enable <= tcu_pkg::IRQ_ENABLE_RESET[0];
    end else if (clk_en) begin
      if (wr_control) begin
        unit_control_reg <= reg_wdata & 8'h9F;
      end
      if (wr_source) begin
        capture_source_select <= reg_wdata[tcu_pkg::SRC_SEL_LSB +: 3];
      end
      if (wr_enable) begin
        capture_irq_enable <= reg_wdata[tcu_pkg::IRQ_CAPTURE_BIT];
      end
    end
  end

  // Capture register: each event overwrites the held count.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      captured_count <= '0;
    end else if (clk_en && capture_event) begin
      captured_count <= reference_count;
    end
  end

  // Sticky flag: set wins over a same-cycle clear; only software or reset clears it.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      capture_flag <= 1'b0;
    end else if (clk_en) begin
      if (capture_event) begin
        capture_flag <= 1'b1;
      end else if (wr_clear && reg_wdata[tcu_pkg::IRQ_CAPTURE_BIT]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // Readback mux; alignment swaps the byte order as a software convenience.
  wire [7:0] cap_low = captured_count[7:0];
  wire [7:0] cap_high = captured_count[15:8];
  always_comb begin
    case (reg_addr)
      tcu_pkg::ADDR_CONTROL: next_rdata = unit_control_reg;
      tcu_pkg::ADDR_SOURCE: next_rdata = {5'h00, capture_source_select};
      tcu_pkg::ADDR_COUNT_LOW: next_rdata = result_alignment ? cap_high : cap_low;
      tcu_pkg::ADDR_COUNT_HIGH: next_rdata = result_alignment ? cap_low : cap_high;
      tcu_pkg::ADDR_IRQ_STATUS: next_rdata = {7'h00, capture_flag};
      tcu_pkg::ADDR_IRQ_ENABLE: next_rdata = {7'h00, capture_irq_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  // Registered outputs: read data one cycle after the strobe, pulse and interrupt from flops.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      capture_pulse <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
      capture_pulse <= capture_event;
      irq <= capture_irq_enable && (capture_flag || capture_event);
    end
  end

  // Checks.
  AST_CAPTURE_VALUE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_event) |=> (captured_count == $past(reference_count)))
    else $error("Captured count does not match reference count.");
  AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_event) |=> capture_flag)
    else $error("Capture did not set the flag.");
  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (reset)
    (capture_flag && !(wr_clear && reg_wdata[0])) |=> capture_flag)
    else $error("Flag cleared without a software clear.");
  AST_PRESCALE_IDLE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !capture_mode) |=> (prescale_count == 4'h0))
    else $error("Prescaler not cleared while idle.");
  AST_PRESCALE_WRAP: assert property (@(posedge core_clk) disable iff (reset)
    (kind == tcu_pkg::TCU_EV_PRESCALED && prescale_count > prescale_last) |->
    (event_mode_field == tcu_pkg::MODE_RISING_4))
    else $error("Prescaler exceeded its terminal count.");
  AST_RISE_CAPTURE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && module_on && event_mode_field == tcu_pkg::MODE_RISING && rise) |-> capture_event)
    else $error("Rising edge not captured.");
  AST_FALL_ONLY: assert property (@(posedge core_clk) disable iff (reset)
    (module_on && event_mode_field == tcu_pkg::MODE_FALLING && capture_event) |-> fall)
    else $error("Falling mode captured without a falling edge.");
  AST_ONE_PER_EDGE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && rise) |=> !rise)
    else $error("Two rising detections from one edge.");
  AST_OVERWRITE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_event && capture_flag) |=> (captured_count == $past(reference_count)))
    else $error("Unread capture was not overwritten.");
  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_flag && capture_irq_enable) |=> irq)
    else $error("Interrupt not raised for enabled flag.");

  // Reset is checked without a disable clause, since the check is about reset itself.
  AST_PRESCALE_RESET: assert property (@(posedge core_clk)
    reset |=> (prescale_count == 4'h0))
    else $error("Prescaler not cleared by reset.");

  // A disabled unit must never capture, whatever the mode field holds.
  AST_NO_CAPTURE_OFF: assert property (@(posedge core_clk) disable iff (reset)
    !module_on |-> !capture_event)
    else $error("Capture while the unit is off.");

  // The pulse output follows every capture by exactly one cycle.
  AST_PULSE_FOLLOWS: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_event) |=> capture_pulse)
    else $error("Capture pulse missing after a capture.");

  // A capture in the same cycle as a software clear must leave the flag set.
  AST_FLAG_SET_WINS: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_event && wr_clear && reg_wdata[tcu_pkg::IRQ_CAPTURE_BIT]) |=> capture_flag)
    else $error("Clear won over a same-cycle capture.");

  // A direct write between prescaled modes must not disturb the running count.
  AST_PRESCALE_KEEP: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && wr_control && capture_mode && kind == tcu_pkg::TCU_EV_PRESCALED && !rise &&
     reg_wdata[tcu_pkg::CTRL_ENABLE_BIT] && reg_wdata[3:1] == 3'h3) |=> $stable(prescale_count))
    else $error("Prescaler count lost on a direct mode switch.");

  // Each non-terminal rising edge advances the prescaler by one.
  AST_PRESCALE_STEP: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && capture_mode && kind == tcu_pkg::TCU_EV_PRESCALED && rise && !prescale_hit) |=>
    (prescale_count == $past(prescale_count) + 4'h1))
    else $error("Prescaler did not advance on a rising edge.");

  // A masked flag must never reach the interrupt pin; this is what makes mode changes safe.
  AST_IRQ_MASKED: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !capture_irq_enable) |=> !irq)
    else $error("Interrupt raised while masked.");

  // Falling mode must capture on every falling edge.
  AST_FALL_CAPTURE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && module_on && event_mode_field == tcu_pkg::MODE_FALLING && fall) |-> capture_event)
    else $error("Falling edge not captured.");

  // Read data stands for one cycle only and is zero otherwise.
  AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && !reg_read) |=> (reg_rdata == 8'h00))
    else $error("Read data present without a read strobe.");

  // With alignment set, the low address returns the high byte of the held count.
  AST_ALIGN_SWAP: assert property (@(posedge core_clk) disable iff (reset)
    (clk_en && reg_read && reg_addr == tcu_pkg::ADDR_COUNT_LOW && result_alignment) |=>
    (reg_rdata == $past(cap_high)))
    else $error("Aligned low read did not return the high byte.");

  // Main scenarios that the bench is expected to reach.
  COV_RISE: cover property (@(posedge core_clk) capture_event && kind == tcu_pkg::TCU_EV_RISE);
  COV_FALL: cover property (@(posedge core_clk) capture_event && kind == tcu_pkg::TCU_EV_FALL);
  COV_PRESCALE16: cover property (@(posedge core_clk)
    capture_event && event_mode_field == tcu_pkg::MODE_RISING_16);
  COV_SET_CLEAR: cover property (@(posedge core_clk) capture_event && wr_clear);
  COV_PRESCALE4: cover property (@(posedge core_clk)
    capture_event && event_mode_field == tcu_pkg::MODE_RISING_4);
endmodule

// >>> hw/tcu_pkg.sv
// Package for the timer capture unit: register map, field layout, reset values and modes.
// Assumes a byte-wide register port with one-cycle read latency.
package tcu_pkg;
  // Register offsets (byte addresses on the plain register port).
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SOURCE = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h6;
  // Control, source and interrupt register fields.
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ALIGN_BIT = 4;
  localparam int CTRL_MODE_LSB = 0;
  localparam int SRC_SEL_LSB = 0;
  localparam int IRQ_CAPTURE_BIT = 0;
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] SOURCE_RESET = 3'h0;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  // Event mode field encodings; any other code is not a capture mode.
  localparam logic [3:0] MODE_FALLING = 4'h4;
  localparam logic [3:0] MODE_RISING = 4'h5;
  localparam logic [3:0] MODE_RISING_4 = 4'h6;
  localparam logic [3:0] MODE_RISING_16 = 4'h7;
  // Prescale terminal counts.
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
  typedef enum logic [1:0] {
    TCU_EV_NONE,
    TCU_EV_FALL,
    TCU_EV_RISE,
    TCU_EV_PRESCALED
  } tcu_event_kind_t;
endpackage

// >>> hw/tcu_sync.sv
// Two-stage synchroniser for one level input.
// Assumes the input may change at any time relative to core_clk.
`timescale 1ns/1ps
module tcu_sync (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic stage_one;

  // First stage feeds only the second stage, so metastability never reaches logic.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

// >>> tb/tcu_src_model.sv
// Far-side model: eight capture source lines and the reference timer count.
// Assumes the bench calls set_line from one process only.
`timescale 1ns/1ps
module tcu_src_model (
  input wire logic core_clk,
  output logic [7:0] src_lines,
  output logic [15:0] ref_count
);
  logic [3:0] phase = 4'h0;
  logic [15:0] count_q = 16'h1200;
  logic [7:0] lines_q = 8'h00;
  assign src_lines = lines_q;
  assign ref_count = count_q;
  // The timer runs on core_clk and steps every 16 cycles, so a value stays put across the capture latency.
  always @(posedge core_clk) begin
    phase <= phase + 4'h1;
    if (phase == 4'hF) begin
      count_q <= count_q + 16'h0101;
    end
  end
  // Moves one line just after a count step and holds it far longer than the two-flop sync needs.
  task automatic set_line(input int sel, input logic level, output logic [15:0] seen);
    @(posedge core_clk iff phase == 4'hF);
    lines_q[sel] <= level;
    #1 seen = count_q;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// >>> tb/test_timer_capture_unit.sv
// Self-checking bench for the capture unit: register tasks and capture scenarios.
// Assumes the source model in tcu_src_model.sv and the register map of tcu_pkg.
`timescale 1ns/1ps
module test_timer_capture_unit;
  localparam logic [3:0] A_CTL = tcu_pkg::ADDR_CONTROL;
  localparam logic [3:0] A_SRC = tcu_pkg::ADDR_SOURCE;
  localparam logic [3:0] A_LO = tcu_pkg::ADDR_COUNT_LOW;
  localparam logic [3:0] A_HI = tcu_pkg::ADDR_COUNT_HIGH;
  localparam logic [3:0] A_ST = tcu_pkg::ADDR_IRQ_STATUS;
  localparam logic [3:0] A_EN = tcu_pkg::ADDR_IRQ_ENABLE;
  localparam logic [3:0] A_CLR = tcu_pkg::ADDR_IRQ_CLEAR;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] src_lines;
  logic [15:0] ref_count;
  logic [15:0] held;
  logic [15:0] scratch;
  logic capture_pulse;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  int pulse_count = 0;
  always #25 core_clk = ~core_clk;
  // Counts capture pulses so the one-cycle output is seen while it stands.
  always @(posedge core_clk) begin
    if (capture_pulse === 1'b1) begin
      pulse_count++;
    end
  end
  tcu_src_model i_src (.core_clk(core_clk), .src_lines(src_lines), .ref_count(ref_count));
  tcu_capture i_dut (.core_clk(core_clk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reference_count(ref_count), .remapped_pin_input(src_lines[0]), .comparator_a_synced(src_lines[1]),
    .comparator_b_synced(src_lines[2]), .pin_change_event(src_lines[3]), .logic_cell_a_out(src_lines[4]),
    .logic_cell_b_out(src_lines[5]), .logic_cell_c_out(src_lines[6]), .logic_cell_d_out(src_lines[7]),
    .capture_pulse(capture_pulse), .irq(irq));
  // One comparison; case inequality keeps an unknown from passing.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled just after that edge.
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 check(what, {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Rising then falling pulses; held keeps the count seen at the last rising edge.
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      i_src.set_line(sel, 1'b1, held);
      i_src.set_line(sel, 1'b0, scratch);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The whole sequence needs about 2400 cycles; the margin covers a stuck handshake.
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rd(A_CTL, 8'h00, "control reset");
    rd(A_ST, 8'h00, "status reset");
    rd(4'h7, 8'h00, "unmapped");
    wr(A_EN, 8'h01);
    for (int s = 0; s < 8; s++) begin
      wr(A_SRC, 8'(s));
      wr(A_CTL, 8'h85);
      pulses((s + 1) % 8, 1);
      rd(A_ST, 8'h00, "unselected source");
      pulses(s, 1);
      check("irq", {15'h0, irq}, 16'h0001);
      rd(A_LO, held[7:0], "count low");
      rd(A_HI, held[15:8], "count high");
      rd(A_ST, 8'h01, "flag kept");
      wr(A_CLR, 8'h01);
      rd(A_ST, 8'h00, "flag cleared");
      wr(A_CTL, 8'h00);
    end
    $display("Source select test done");
    wr(A_SRC, 8'h00);
    wr(A_CTL, 8'h84);
    i_src.set_line(0, 1'b1, scratch);
    rd(A_ST, 8'h00, "rising in falling mode");
    i_src.set_line(0, 1'b0, held);
    rd(A_ST, 8'h01, "falling capture");
    rd(A_LO, held[7:0], "falling count");
    wr(A_CLR, 8'h01);
    $display("Falling edge test done");
    // Each prescaled mode: terminal edge captures, then the count restarts and overwrites the unread value.
    for (int m = 0; m < 2; m++) begin
      wr(A_CTL, m ? 8'h87 : 8'h86);
      for (int k = 0; k < 2; k++) begin
        pulses(0, m ? 15 : 3);
        rd(A_ST, 8'h00, "before terminal edge");
        pulses(0, 1);
        rd(A_ST, 8'h01, "terminal edge");
        wr(A_CLR, 8'h01);
      end
      rd(A_HI, held[15:8], "overwritten count");
      rd(A_LO, held[7:0], "overwritten count low");
      wr(A_CTL, 8'h00);
    end
    $display("Prescaler test done");
    wr(A_CTL, 8'h86);
    pulses(0, 2);
    wr(A_CTL, 8'h00);
    wr(A_CTL, 8'h86);
    pulses(0, 3);
    rd(A_ST, 8'h00, "prescaler cleared by off");
    pulses(0, 1);
    rd(A_ST, 8'h01, "capture after off");
    wr(A_CLR, 8'h01);
    wr(A_CTL, 8'h00);
    wr(A_EN, 8'h00);
    wr(A_CTL, 8'h87);
    pulses(0, 3);
    wr(A_CTL, 8'h86);
    pulses(0, 1);
    rd(A_ST, 8'h01, "direct switch keeps count");
    check("irq masked", {15'h0, irq}, 16'h0000);
    wr(A_EN, 8'h01);
    @(posedge core_clk);
    #1 check("irq enabled", {15'h0, irq}, 16'h0001);
    wr(A_CLR, 8'h01);
    @(posedge core_clk);
    #1 check("irq cleared", {15'h0, irq}, 16'h0000);
    $display("Mode change test done");
    // Alignment swaps the byte order of the held count on readback.
    wr(A_CTL, 8'h96);
    rd(A_LO, held[15:8], "aligned low");
    rd(A_HI, held[7:0], "aligned high");
    // Eight source captures, one falling, four prescaled and two in the mode test.
    check("capture pulses", 16'(pulse_count), 16'h000F);
    $display("Alignment and pulse test done");
    give_verdict();
  end
endmodule
